// ===== rtl/vpr_pkg.sv
// Shared constants, register map and helper functions of the voltage PWM regulator.
package vpr_pkg;
	// -------------------------------------------------------------
	// Widths
	// -------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int VEL_W = 23;
	localparam int AMP_W = 8;
	localparam int CS_W = 5;
	localparam int PH_W = 11;
	localparam int CNT_W = 8;
	localparam int GAIN_W = 4;
	localparam int GAIN_SHIFT = 2;

	// -------------------------------------------------------------
	// Register offsets, fields and reset values
	// -------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] SWV_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] HIV_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] CUR_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] STA_OFS = 8'h10;
	localparam int CFG_AUTO_BIT = 0;
	localparam int CFG_FREQ_LSB = 1;
	localparam int CFG_BLANK_LSB = 3;
	localparam int CFG_GAIN_LSB = 8;
	localparam int CFG_AMPL_LSB = 16;
	localparam logic [DATA_W-1:0] CFG_MASK = 32'h00FF_0F1F;
	localparam logic [DATA_W-1:0] CFG_RST = 32'h00FF_0401;
	localparam logic [VEL_W-1:0] SWV_RST = 23'h7F_FFFF;
	localparam logic [VEL_W-1:0] HIV_RST = 23'h7F_FFFF;
	localparam logic [CS_W-1:0] CUR_RST = 5'h10;
	localparam int STA_VMODE_BIT = 8;
	localparam int STA_START_BIT = 9;
	localparam int STA_STUCK_BIT = 10;

	// -------------------------------------------------------------
	// Bus codes and chopper timing counts
	// -------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [PH_W-1:0] PH_STEP = 11'h002;
	localparam logic [PH_W-1:0] DIV_SEL0 = 11'h400;
	localparam logic [PH_W-1:0] DIV_SEL1 = 11'h2AB;
	localparam logic [PH_W-1:0] DIV_SEL2 = 11'h200;
	localparam logic [PH_W-1:0] DIV_SEL3 = 11'h19A;
	localparam logic [CNT_W-1:0] BLANK_SEL0 = 8'h10;
	localparam logic [CNT_W-1:0] BLANK_SEL1 = 8'h18;
	localparam logic [CNT_W-1:0] BLANK_SEL2 = 8'h24;
	localparam logic [CNT_W-1:0] BLANK_SEL3 = 8'h36;
	localparam logic [AMP_W-1:0] MIN_REG_SCALE = 8'h08;

	// Phase divisor: the phase advances by two per clock, so a period is div/2 clocks.
	function automatic logic [PH_W-1:0] chop_div(input logic [1:0] sel);
		chop_div = DIV_SEL0;
		unique case (sel)
			2'h0: chop_div = DIV_SEL0;
			2'h1: chop_div = DIV_SEL1;
			2'h2: chop_div = DIV_SEL2;
			2'h3: chop_div = DIV_SEL3;
		endcase
	endfunction

	// Blank time in clocks for each selection.
	function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] sel);
		blank_cycles = BLANK_SEL0;
		unique case (sel)
			2'h0: blank_cycles = BLANK_SEL0;
			2'h1: blank_cycles = BLANK_SEL1;
			2'h2: blank_cycles = BLANK_SEL2;
			2'h3: blank_cycles = BLANK_SEL3;
		endcase
	endfunction
endpackage

// ===== rtl/vpr_chop_if.sv
// Link between the controller and the chopper period generator.
`timescale 1ns/10ps
`default_nettype none
interface vpr_chop_if;
	import vpr_pkg::*;
	logic [AMP_W-1:0] amplitude;
	logic [AMP_W-1:0] sine;
	logic [1:0] freq_sel;
	logic [1:0] blank_sel;
	logic on_phase;
	logic sample_strobe;
	logic period_end;
	modport gen (input amplitude, sine, freq_sel, blank_sel, output on_phase, sample_strobe, period_end);
	modport ctl (output amplitude, sine, freq_sel, blank_sel, input on_phase, sample_strobe, period_end);
endinterface
`default_nettype wire

// ===== rtl/vpr_pwm_gen.sv
// Chopper period generator with on-phase compare and current sample strobe.
`timescale 1ns/10ps
`default_nettype none
module vpr_pwm_gen (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Controller link
	vpr_chop_if.gen chop
);
	import vpr_pkg::*;
	localparam int P_W = 2 * AMP_W + PH_W;

	logic [PH_W-1:0] phase_reg, phase_next, thr_reg, thr_next, div, sum;
	logic [CNT_W-1:0] on_cnt_reg, on_cnt_next;
	logic on_reg, on_next, strobe_reg, strobe_next, end_reg, end_next, wrap;
	logic [P_W-1:0] prod;

	// The odd divisor 683 is exact on average because the phase steps by two.
	always_comb begin
		div = chop_div(chop.freq_sel);
		sum = phase_reg + PH_STEP;
		wrap = sum >= div;
		phase_next = wrap ? sum - div : sum;
		prod = P_W'(chop.amplitude) * P_W'(chop.sine) * P_W'(div);
		thr_next = wrap ? prod[P_W-1:2*AMP_W] : thr_reg;
		on_next = phase_next < thr_next;
		on_cnt_next = !on_next ? '0 : (on_cnt_reg == '1 ? on_cnt_reg : on_cnt_reg + 1'b1);
		strobe_next = on_reg && !on_next && on_cnt_reg >= blank_cycles(chop.blank_sel);
		end_next = wrap;
	end

	// Threshold is latched per period so a mid-period amplitude change cannot glitch the pulse.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= '0;
			thr_reg <= '0;
			on_cnt_reg <= '0;
			on_reg <= 1'b0;
			strobe_reg <= 1'b0;
			end_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			thr_reg <= thr_next;
			on_cnt_reg <= on_cnt_next;
			on_reg <= on_next;
			strobe_reg <= strobe_next;
			end_reg <= end_next;
		end
	end

	assign chop.on_phase = on_reg;
	assign chop.sample_strobe = strobe_reg;
	assign chop.period_end = end_reg;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	logic [PH_W-1:0] per_cnt_reg;
	logic per_ok_reg;
	logic [1:0] freq_q_reg;

	// Period length counter, trusted only after a whole period at one setting.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_cnt_reg <= '0;
			per_ok_reg <= 1'b0;
			freq_q_reg <= '0;
		end else begin
			per_cnt_reg <= end_reg ? '0 : per_cnt_reg + 1'b1;
			freq_q_reg <= chop.freq_sel;
			per_ok_reg <= (freq_q_reg != chop.freq_sel) ? 1'b0 : (end_reg ? 1'b1 : per_ok_reg);
		end
	end

	sample_in_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
		strobe_reg |-> $past(on_reg) && !on_reg) else $error("sample strobe outside on phase");
	blank_min_a: assert property (@(posedge hclk) disable iff (!hresetn)
		strobe_reg |-> $past(on_cnt_reg) >= blank_cycles($past(chop.blank_sel)))
		else $error("sample taken before blank time");
	period_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		end_reg && per_ok_reg && freq_q_reg == chop.freq_sel |->
		per_cnt_reg == (div >> 1) - 1'b1 || per_cnt_reg == (div >> 1))
		else $error("chopper period length wrong");
	sample_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) strobe_reg);
endmodule
`default_nettype wire

// ===== rtl/vpr_regulator.sv
// Proportional amplitude regulator fed by on-phase current samples.
`timescale 1ns/10ps
`default_nettype none
module vpr_regulator (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic update_en,
	input wire logic sample_strobe,
	input wire logic standstill,
	input wire logic load,
	input wire logic [vpr_pkg::AMP_W-1:0] load_value,
	input wire logic [vpr_pkg::GAIN_W-1:0] gain,
	// Current
	input wire logic [vpr_pkg::AMP_W-1:0] measured,
	input wire logic [vpr_pkg::AMP_W-1:0] target,
	// Result
	output logic [vpr_pkg::AMP_W-1:0] scale,
	output logic stuck
);
	import vpr_pkg::*;

	logic [AMP_W-1:0] scale_reg, scale_next;
	logic stuck_reg, stuck_next, step;
	logic signed [AMP_W:0] err;
	logic signed [AMP_W+5:0] delta, sum;

	// Error times gain, divided by four, added to the scale and saturated to the amplitude range.
	always_comb begin
		err = $signed({1'b0, target}) - $signed({1'b0, measured});
		delta = ($signed(14'(err)) * $signed(14'({1'b0, gain}))) >>> GAIN_SHIFT;
		sum = $signed(14'({1'b0, scale_reg})) + delta;
		step = update_en && sample_strobe && gain != '0 && !stuck_reg;
		stuck_next = !standstill && (stuck_reg || (update_en && scale_reg < MIN_REG_SCALE));
		scale_next = scale_reg;
		if (load) begin
			scale_next = load_value;
		end else if (step) begin
			if (sum < 0) begin
				scale_next = '0;
			end else if (sum > 14'sd255) begin
				scale_next = '1;
			end else begin
				scale_next = sum[AMP_W-1:0];
			end
		end
	end

	// A low amplitude in motion locks the loop until standstill; this mirrors the real limit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scale_reg <= '0;
			stuck_reg <= 1'b0;
		end else begin
			scale_reg <= scale_next;
			stuck_reg <= stuck_next;
		end
	end

	assign scale = scale_reg;
	assign stuck = stuck_reg;

	zero_gain_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gain == '0 && !load |=> $stable(scale_reg)) else $error("scale moved with zero gain");
	stuck_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		stuck_reg && !load |=> $stable(scale_reg)) else $error("stuck regulator moved");
	stuck_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		standstill |=> !stuck_reg) else $error("stuck not cleared at standstill");
	stuck_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(stuck_reg));
endmodule
`default_nettype wire

// ===== rtl/vpr_top.sv
// Voltage-mode PWM amplitude controller with AHB-Lite register slave.
//
// Notes on behaviour
// - Autoscale bit 1 regulates from measured current, 0 uses fixed user amplitude.
// - Fixed mode takes no current samples and keeps the amplitude steady.
// - Fixed mode amplitude ignores current scale changes, standstill reduction included.
// - Frequency select gives 2/1024, 2/683, 2/512, 2/410 of clock.
// - Automatic mode samples current only in on phase, proportional regulator follows.
// - Regulator gain is proportional coefficient, 1 slowest to 15 fastest.
// - Sampling needs on time beyond blank time at the chosen frequency.
// - Too low amplitude in motion may stick; standstill recovers it.
// - Automatic regulation starts only at standstill; early motion gets zero current.
// - Voltage mode only below switching velocity threshold, other chopper above.
// - Re-entering voltage mode at falling velocity starts from user amplitude.
// - Upper velocity limit is the lower of the two thresholds.
// - Regulation freezes while the target current is zero.
`timescale 1ns/10ps
`default_nettype none
module vpr_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [vpr_pkg::DATA_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [vpr_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic [vpr_pkg::DATA_W-1:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Motion state from the ramp generator
	input wire logic [vpr_pkg::VEL_W-1:0] velocity,
	input wire logic standstill,
	input wire logic target_zero,
	input wire logic [vpr_pkg::AMP_W-1:0] sine_value,
	// Coil current converter pins
	input wire logic [vpr_pkg::AMP_W-1:0] coil_current,
	// Bridge drive
	output logic pwm_on,
	output logic voltage_mode
);
	import vpr_pkg::*;

	// -------------------------------------------------------------
	// Pin synchroniser
	// -------------------------------------------------------------
	logic [AMP_W-1:0] cur_meta_reg, cur_sync_reg;

	// The converter word changes slowly against hclk; a sample may mix two codes once.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur_meta_reg <= '0;
			cur_sync_reg <= '0;
		end else begin
			cur_meta_reg <= coil_current;
			cur_sync_reg <= cur_meta_reg;
		end
	end

	// -------------------------------------------------------------
	// Register file and bus slave
	// -------------------------------------------------------------
	logic [DATA_W-1:0] cfg_reg, cfg_next, hrdata_reg, hrdata_next, rd_word;
	logic [VEL_W-1:0] swv_reg, swv_next, hiv_reg, hiv_next;
	logic [CS_W-1:0] cur_reg, cur_next;
	logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic wr_pend_reg, wr_pend_next, ap_valid, hit;
	logic vmode_reg, vmode_next, started_reg, started_next;
	logic [AMP_W-1:0] amp_reg, amp_next, scale;
	logic stuck;

	// Writes land in the data phase; reads see those values through the next-state terms.
	always_comb begin
		ap_valid = hsel && htrans == HTRANS_NONSEQ && hready;
		hit = haddr[DATA_W-1:ADDR_W] == '0;
		wr_pend_next = ap_valid && hwrite && hsize == HSIZE_WORD && hit;
		wr_addr_next = haddr[ADDR_W-1:0];
		cfg_next = cfg_reg;
		swv_next = swv_reg;
		hiv_next = hiv_reg;
		cur_next = cur_reg;
		if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				CFG_OFS: cfg_next = hwdata & CFG_MASK;
				SWV_OFS: swv_next = hwdata[VEL_W-1:0];
				HIV_OFS: hiv_next = hwdata[VEL_W-1:0];
				CUR_OFS: cur_next = hwdata[CS_W-1:0];
				default: ;
			endcase
		end
		rd_word = '0;
		unique case (haddr[ADDR_W-1:0])
			CFG_OFS: rd_word = cfg_next;
			SWV_OFS: rd_word[VEL_W-1:0] = swv_next;
			HIV_OFS: rd_word[VEL_W-1:0] = hiv_next;
			CUR_OFS: rd_word[CS_W-1:0] = cur_next;
			STA_OFS: begin
				rd_word[AMP_W-1:0] = scale;
				rd_word[STA_VMODE_BIT] = vmode_reg;
				rd_word[STA_START_BIT] = started_reg;
				rd_word[STA_STUCK_BIT] = stuck;
			end
			default: ;
		endcase
		hrdata_next = hrdata_reg;
		if (ap_valid && !hwrite) begin
			hrdata_next = hit ? rd_word : '0;
		end
	end

	// Zero wait states, so hreadyout and hresp are constant flops after reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= CFG_RST;
			swv_reg <= SWV_RST;
			hiv_reg <= HIV_RST;
			cur_reg <= CUR_RST;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			hrdata_reg <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			swv_reg <= swv_next;
			hiv_reg <= hiv_next;
			cur_reg <= cur_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = hrdata_reg;

	// -------------------------------------------------------------
	// Mode selection and amplitude control
	// -------------------------------------------------------------
	logic autoscale, reload, reg_update;
	logic [AMP_W-1:0] user_amplitude, target;
	logic [VEL_W-1:0] vel_limit;
	vpr_chop_if chop ();

	// Velocity gating, start-up latch and the amplitude handed to the chopper.
	always_comb begin
		autoscale = cfg_reg[CFG_AUTO_BIT];
		user_amplitude = cfg_reg[CFG_AMPL_LSB +: AMP_W];
		target = {cur_reg, 3'h7};
		vel_limit = (swv_reg < hiv_reg) ? swv_reg : hiv_reg;
		vmode_next = velocity < vel_limit;
		reload = vmode_next && !vmode_reg;
		started_next = autoscale && (started_reg || (standstill && vmode_reg));
		reg_update = autoscale && vmode_reg && started_reg && !target_zero;
		if (!vmode_reg) begin
			amp_next = '0;
		end else if (!autoscale) begin
			amp_next = user_amplitude;
		end else if (started_reg) begin
			amp_next = scale;
		end else begin
			amp_next = '0;
		end
	end

	// The regulator value is held while the other chopper runs; re-entry reloads it with the user amplitude.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vmode_reg <= 1'b0;
			started_reg <= 1'b0;
			amp_reg <= '0;
		end else begin
			vmode_reg <= vmode_next;
			started_reg <= started_next;
			amp_reg <= amp_next;
		end
	end

	assign chop.amplitude = amp_reg;
	assign chop.sine = sine_value;
	assign chop.freq_sel = cfg_reg[CFG_FREQ_LSB +: 2];
	assign chop.blank_sel = cfg_reg[CFG_BLANK_LSB +: 2];
	assign pwm_on = chop.on_phase;
	assign voltage_mode = vmode_reg;

	// -------------------------------------------------------------
	// Sub-blocks
	// -------------------------------------------------------------
	vpr_pwm_gen u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.chop(chop.gen)
	);

	vpr_regulator u_reg (
		.hclk(hclk),
		.hresetn(hresetn),
		.update_en(reg_update),
		.sample_strobe(chop.sample_strobe),
		.standstill(standstill),
		.load(reload),
		.load_value(user_amplitude),
		.gain(cfg_reg[CFG_GAIN_LSB +: GAIN_W]),
		.measured(cur_sync_reg),
		.target(target),
		.scale(scale),
		.stuck(stuck)
	);

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	fixed_ampl_a: assert property (
		vmode_reg && !autoscale && $stable(cfg_reg) ##1 vmode_reg && $stable(cfg_reg)
		|=> amp_reg == $past(user_amplitude)) else $error("fixed amplitude not user value");
	fixed_no_reg_a: assert property (
		!autoscale && vmode_reg && vmode_next |=> $stable(scale)) else $error("fixed mode regulated");
	vel_gate_a: assert property (
		velocity >= swv_reg || velocity >= hiv_reg |=> !vmode_reg) else $error("voltage mode above limit");
	vel_enter_a: assert property (
		velocity < swv_reg && velocity < hiv_reg |=> vmode_reg) else $error("voltage mode not entered");
	reentry_load_a: assert property (
		$rose(vmode_reg) |-> scale == $past(user_amplitude)) else $error("re-entry amplitude wrong");
	startup_zero_a: assert property (
		autoscale && vmode_reg && !started_reg |=> amp_reg == '0) else $error("amplitude before start-up");
	startup_gate_a: assert property (
		$rose(started_reg) |-> $past(standstill) && $past(vmode_reg)) else $error("start-up in motion");
	zero_target_a: assert property (
		target_zero && vmode_reg && vmode_next |=> $stable(scale)) else $error("regulation not frozen");
	auto_follow_a: assert property (
		autoscale && started_reg && vmode_reg ##1 autoscale && vmode_reg |-> amp_reg == $past(scale))
		else $error("automatic amplitude not scale");
	bus_rd_a: assert property (
		hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr == 32'h0000_000C && !wr_pend_reg
		|=> hrdata[CS_W-1:0] == $past(cur_reg)) else $error("read data wrong");

	reentry_c: cover property ($rose(vmode_reg));
	started_c: cover property ($rose(started_reg));
	switch_out_c: cover property ($fell(vmode_reg) ##[1:20] $rose(vmode_reg));
endmodule
`default_nettype wire

// ===== testbench/vpr_coil_model.sv
// Behavioural coil and sense path that answers the bridge drive with a current code.
`timescale 1ns/10ps
`default_nettype none
module vpr_coil_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bridge side
	input wire logic pwm_on,
	output logic [vpr_pkg::AMP_W-1:0] coil_current
);
	import vpr_pkg::*;
	logic pwm_d;
	logic [AMP_W-1:0] cur_next;

	// ------------------------------------------------------------
	// Current build-up
	// ------------------------------------------------------------
	// Current rises one code per on clock and restarts at each period.
	// It holds through the off phase, so a late sample still sees the peak.
	always_comb begin
		cur_next = coil_current;
		if (pwm_on && !pwm_d) begin
			cur_next = 8'h01;
		end else if (pwm_on && coil_current != 8'hFF) begin
			cur_next = coil_current + 8'h01;
		end
	end

	// Registers of the coil model.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_d <= 1'b0;
			coil_current <= 8'h00;
		end else begin
			pwm_d <= pwm_on;
			coil_current <= cur_next;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/vpr_top_tb.sv
// Self-checking testbench of the voltage PWM amplitude controller.
`timescale 1ns/10ps
`default_nettype none
module vpr_top_tb;
	import vpr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, pwm_on, voltage_mode;
	logic [22:0] velocity = '0;
	logic [22:0] sw, hv, lim;
	logic standstill = 1'b1;
	logic target_zero = 1'b0;
	logic [7:0] sine_value = 8'hFF;
	logic [7:0] coil_current;
	logic [31:0] rd, s0;
	int error_cnt = 0;
	int cmp_count = 0;
	int per2, on1, thr, a, sv, n;
	int dv[4] = '{1024, 683, 512, 410};
	logic [31:0] rst_tab[4] = '{32'h00FF_0401, 32'h007F_FFFF, 32'h007F_FFFF, 32'h0000_0010};

	// 20 MHz clock.
	always #25 hclk = ~hclk;

	vpr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .velocity(velocity), .standstill(standstill),
		.target_zero(target_zero), .sine_value(sine_value), .coil_current(coil_current),
		.pwm_on(pwm_on), .voltage_mode(voltage_mode));

	vpr_coil_model coil (.hclk(hclk), .hresetn(hresetn), .pwm_on(pwm_on), .coil_current(coil_current));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Prints the verdict and stops; the watchdog ends here too.
	task automatic complete_run;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One single AHB-Lite word transfer; read data lands in rd.
	task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge hclk);
	endtask

	// Measures two whole chopper periods and the on clocks of the first one.
	task automatic meas;
		logic prev;
		int k;
		prev = 1'b1;
		k = 0;
		per2 = 0;
		on1 = 1;
		repeat (3000) begin
			@(negedge hclk);
			if (pwm_on === 1'b1 && prev === 1'b0) break;
			prev = pwm_on;
		end
		prev = 1'b1;
		while (k < 2 && per2 < 3000) begin
			@(negedge hclk);
			per2++;
			if (pwm_on === 1'b1 && prev === 1'b0) k++;
			else if (k == 0 && pwm_on === 1'b1) on1++;
			prev = pwm_on;
		end
	endtask

	function automatic logic [31:0] cfgw(input logic au, input logic [1:0] f, input logic [3:0] g,
		input logic [7:0] am);
		cfgw = {8'h00, am, 4'h0, g, 3'h0, 2'h0, f, au};
	endfunction

	function automatic logic vm_exp(input logic [22:0] v, input logic [22:0] s, input logic [22:0] h);
		vm_exp = v < ((s < h) ? s : h);
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		s0 = $urandom(37904);
		repeat (3) @(posedge hclk);
		chk(hrdata, 32'h0000_0000);
		chk({28'h0, hreadyout, hresp, pwm_on, voltage_mode}, 32'h0000_0008);
		hresetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 32'(i * 4), 32'h0);
			chk(rd, rst_tab[i]);
		end
		s0 = $urandom;
		bus(1'b1, 32'h0000_0000, s0);
		bus(1'b0, 32'h0000_0000, 32'h0);
		chk(rd, s0 & 32'h00FF_0F1F);
		bus(1'b0, 32'h0000_0020, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(1'b0, 32'h0000_0100, 32'h0);
		chk(rd, 32'h0000_0000);
		// Velocity window against random thresholds, with both edges of the limit.
		for (int i = 0; i < 12; i++) begin
			sw = 23'($urandom);
			hv = 23'($urandom);
			lim = (sw < hv) ? sw : hv;
			bus(1'b1, 32'h0000_0004, {9'h0, sw});
			bus(1'b1, 32'h0000_0008, {9'h0, hv});
			velocity <= (i % 3 == 0) ? lim : (i % 3 == 1) ? lim - 23'h1 : 23'($urandom);
			idle(3);
			@(negedge hclk);
			chk({31'h0, voltage_mode}, {31'h0, vm_exp(velocity, sw, hv)});
			@(posedge hclk);
		end
		bus(1'b1, 32'h0000_0004, 32'h007F_FFFF);
		bus(1'b1, 32'h0000_0008, 32'h007F_FFFF);
		velocity <= 23'h0;
		// Fixed amplitude at every frequency; current scale changes must not matter.
		for (int f = 0; f < 4; f++) begin
			a = $urandom_range(255, 64);
			sv = $urandom_range(255, 128);
			bus(1'b1, 32'h0000_0000, cfgw(1'b0, 2'(f), 4'h4, 8'(a)));
			sine_value <= 8'(sv);
			thr = (a * sv * dv[f]) >> 16;
			for (int r = 0; r < 2; r++) begin
				meas();
				meas();
				chk(32'(per2), 32'(dv[f]));
				chk(32'(on1 - (thr + 1) / 2 <= 1 && (thr + 1) / 2 - on1 <= 1), 32'h1);
				@(posedge hclk);
				bus(1'b1, 32'h0000_000C, 32'($urandom_range(31, 0)));
			end
		end
		// Automatic mode entered in motion stays unstarted with no drive.
		sine_value <= 8'hFF;
		standstill <= 1'b0;
		bus(1'b1, 32'h0000_0000, cfgw(1'b1, 2'h0, 4'h2, 8'h40));
		// The period already running keeps its latched threshold, so let it end first.
		idle(600);
		n = 0;
		repeat (1100) begin
			@(negedge hclk);
			n += (pwm_on === 1'b1) ? 1 : 0;
		end
		chk(32'(n), 32'h0);
		@(posedge hclk);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({31'h0, rd[9]}, 32'h1 - 32'h1);
		// Standstill start-up, then settle before any motion.
		bus(1'b1, 32'h0000_000C, 32'h0000_000F);
		standstill <= 1'b1;
		idle(25000);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({31'h0, rd[9]}, 32'h1);
		chk(32'(int'(rd[7:0]) >= 60 && int'(rd[7:0]) <= 68), 32'h1);
		// Zero target current freezes the scale.
		target_zero <= 1'b1;
		s0 = rd;
		bus(1'b1, 32'h0000_000C, 32'h0000_001F);
		idle(2000);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({24'h0, rd[7:0]}, {24'h0, s0[7:0]});
		// Leave voltage mode and come back below the limit.
		bus(1'b1, 32'h0000_0004, 32'h0000_03E8);
		velocity <= 23'h0007_D0;
		idle(5);
		@(negedge hclk);
		chk({31'h0, voltage_mode}, 32'h0);
		@(posedge hclk);
		velocity <= 23'h0001_F4;
		idle(3);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({23'h0, rd[8:0]}, 32'h0000_0140);
		// Tiny target in motion drives the scale too low, standstill frees it.
		target_zero <= 1'b0;
		standstill <= 1'b0;
		bus(1'b1, 32'h0000_000C, 32'h0000_0000);
		idle(16000);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({31'h0, rd[10]}, 32'h1);
		standstill <= 1'b1;
		idle(4);
		bus(1'b0, 32'h0000_0010, 32'h0);
		chk({31'h0, rd[10]}, 32'h0);
		complete_run();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#4_500_000;
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
